//--- hw/bid_top.sv
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module bid_top
   import bid_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter samples
   input wire bid_sample_s sample,
   // external interrupt level for pin 2
   input wire logic irq_level,
   // output pins
   output logic chan1_output_pin,
   output logic chan2_output_pin,
   // load current codes per channel
   output logic [7:0] load_level_ch1,
   output logic [7:0] load_level_ch2,
   output logic load_pulse_ch1,
   output logic load_pulse_ch2
);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // registers
   logic [31:0] dp_ctrl;
   logic [31:0] pin_ctrl;
   logic [31:0] filt_cfg [4];
   logic [31:0] thr [4];
   logic [31:0] load_en_cfg;
   logic [31:0] pulse_level_cfg;
   logic [31:0] pulse_duration_cfg;
   logic [31:0] const_level_cfg;
   wire logic [7:0] path_out;
   logic [7:0] status;

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      return r;
   endfunction : merge

   // address is mapped
   function automatic logic mapped(input logic [7:0] a);
      return (a == DP_CTRL_ADDR) || (a == PIN_CTRL_ADDR) || (a[7:4] == FILT_CFG_ADDR[7:4])
         || (a[7:4] == THR_ADDR[7:4]) || (a[7:4] == LOAD_EN_ADDR[7:4]) || (a == STATUS_ADDR);
   endfunction : mapped

   // comparator decision, keeps prev on equality except in CMP_BELOW
   function automatic logic compare(input logic [1:0] m, input logic [7:0] s, input logic [7:0] hi,
                                    input logic [7:0] lo, input logic prev);
      logic r;
      r = prev;
      case (m)
         CMP_HYST:
         begin
            if (s > hi) r = 1'b1;
            else if (s < lo) r = 1'b0;
         end
         CMP_MID:
         begin
            if (s > lo && s < hi) r = 1'b1;
            else if (s < lo || s > hi) r = 1'b0;
         end
         CMP_ABOVE:
         begin
            if (s > hi) r = 1'b1;
            else if (s < hi) r = 1'b0;
         end
         default: r = (s <= hi);
      endcase
      return r;
   endfunction : compare

   // shared per-path settings
   bid_path_cfg_s cfg [4];
   genvar gp, gc;
   generate
      for (gp = 0; gp < 4; gp++)
      begin : g_cfg
         assign cfg[gp].en = filt_cfg[gp][FILT_EN_BIT];
         assign cfg[gp].updown = filt_cfg[gp][FILT_MODE_BIT];
         assign cfg[gp].len = filt_cfg[gp][12:0];
         assign cfg[gp].hi = thr[gp][15:8];
         assign cfg[gp].lo = thr[gp][7:0];
         assign cfg[gp].cmode = dp_ctrl[CMP_MODE_LSB + 2*gp +: 2];
      end
   endgenerate

   // write channel: take address and data together
   logic wr_go;
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(s_axi_awaddr) && s_axi_awaddr != STATUS_ADDR ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // register writes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dp_ctrl <= DP_CTRL_RST;
         pin_ctrl <= PIN_CTRL_RST;
         filt_cfg <= '{default: FILT_CFG_RST};
         thr <= '{default: THR_RST};
         load_en_cfg <= LOAD_RST;
         pulse_level_cfg <= LOAD_RST;
         pulse_duration_cfg <= LOAD_RST;
         const_level_cfg <= LOAD_RST;
      end
      else if (wr_go)
      begin
         case (s_axi_awaddr[7:4])
            4'h0:
            begin
               if (s_axi_awaddr[3:0] == DP_CTRL_ADDR[3:0])
                  dp_ctrl <= merge(dp_ctrl, s_axi_wdata, s_axi_wstrb) & 32'h0000_3FFF;
               if (s_axi_awaddr[3:0] == PIN_CTRL_ADDR[3:0])
                  pin_ctrl <= merge(pin_ctrl, s_axi_wdata, s_axi_wstrb) & 32'h0000_0005;
            end
            4'h1: filt_cfg[s_axi_awaddr[3:2]] <= merge(filt_cfg[s_axi_awaddr[3:2]], s_axi_wdata, s_axi_wstrb)
               & 32'h0000_DFFF;
            4'h2: thr[s_axi_awaddr[3:2]] <= merge(thr[s_axi_awaddr[3:2]], s_axi_wdata, s_axi_wstrb) & 32'h0000_FFFF;
            4'h3:
            begin
               case (s_axi_awaddr[3:2])
                  2'h0: load_en_cfg <= merge(load_en_cfg, s_axi_wdata, s_axi_wstrb) & 32'h0000_C000;
                  2'h1: pulse_level_cfg <= merge(pulse_level_cfg, s_axi_wdata, s_axi_wstrb) & 32'h0000_00FF;
                  2'h2: pulse_duration_cfg <= merge(pulse_duration_cfg, s_axi_wdata, s_axi_wstrb)
                     & 32'h0000_0FFF;
                  default: const_level_cfg <= merge(const_level_cfg, s_axi_wdata, s_axi_wstrb) & 32'h0000_003F;
               endcase
            end
            default: ;
         endcase
      end
   end

   // read channel, one cycle latency
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr[7:4])
               4'h0: s_axi_rdata <= (s_axi_araddr[3:0] == DP_CTRL_ADDR[3:0]) ? dp_ctrl :
                  (s_axi_araddr[3:0] == PIN_CTRL_ADDR[3:0]) ? pin_ctrl : 32'h0000_0000;
               4'h1: s_axi_rdata <= filt_cfg[s_axi_araddr[3:2]];
               4'h2: s_axi_rdata <= thr[s_axi_araddr[3:2]];
               4'h3: s_axi_rdata <= (s_axi_araddr[3:2] == 2'h0) ? load_en_cfg :
                  (s_axi_araddr[3:2] == 2'h1) ? pulse_level_cfg :
                  (s_axi_araddr[3:2] == 2'h2) ? pulse_duration_cfg : const_level_cfg;
               4'h4: s_axi_rdata <= (s_axi_araddr[3:0] == STATUS_ADDR[3:0]) ? {24'h00_0000, status} : 32'h0000_0000;
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // status snapshot of all filter outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status <= 8'h00;
      else
         status <= path_out;
   end

   // per-channel decimator and datapaths
   generate
      for (gc = 0; gc < 2; gc++)
      begin : g_ch
         logic [10:0] acc;
         logic [2:0] cnt;
         logic upd;
         logic [7:0] smp;
         logic [10:0] sum;
         logic [2:0] last;
         logic hit;
         assign hit = sample.valid && (sample.chan == 1'(gc));
         assign sum = acc + {3'h0, sample.data};
         assign last = 3'((1 << dp_ctrl[DECIM_RATIO_LSB +: 2]) - 1);
         // averaging decimator
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               acc <= 11'h000;
               cnt <= 3'h0;
               upd <= 1'b0;
               smp <= 8'h00;
            end
            else
            begin
               upd <= 1'b0;
               if (hit)
               begin
                  if (!dp_ctrl[DECIM_EN_BIT] || dp_ctrl[DECIM_RATIO_LSB +: 2] == 2'h0)
                  begin
                     smp <= sample.data;
                     upd <= 1'b1;
                     acc <= 11'h000;
                     cnt <= 3'h0;
                  end
                  else if (cnt >= last)
                  begin
                     smp <= 8'(sum >> dp_ctrl[DECIM_RATIO_LSB +: 2]);
                     upd <= 1'b1;
                     acc <= 11'h000;
                     cnt <= 3'h0;
                  end
                  else
                  begin
                     acc <= sum;
                     cnt <= cnt + 3'h1;
                  end
               end
            end
         end

         for (gp = 0; gp < 4; gp++)
         begin : g_path
            logic cmp;
            logic out;
            logic [12:0] fc;
            logic nc;
            assign nc = compare(cfg[gp].cmode, smp, cfg[gp].hi, cfg[gp].lo, cmp);
            assign path_out[gc*4 + gp] = out;
            // comparator and debounce, own state per channel
            always_ff @(posedge aclk)
            begin
               if (!aresetn || !cfg[gp].en)
               begin
                  cmp <= 1'b0;
                  out <= 1'b0;
                  fc <= 13'h0000;
               end
               else if (upd)
               begin
                  cmp <= nc;
                  if (cfg[gp].len == 13'h0000)
                  begin
                     out <= nc;
                     fc <= 13'h0000;
                  end
                  else if (nc)
                  begin
                     if (out && !cfg[gp].updown)
                        fc <= cfg[gp].len;
                     else if (fc >= cfg[gp].len - 13'h0001)
                     begin
                        fc <= cfg[gp].len;
                        out <= 1'b1;
                     end
                     else
                        fc <= fc + 13'h0001;
                  end
                  else if (!out && !cfg[gp].updown)
                     fc <= 13'h0000;
                  else if (fc <= 13'h0001)
                  begin
                     fc <= 13'h0000;
                     out <= 1'b0;
                  end
                  else
                     fc <= fc - 13'h0001;
               end
            end
         end
      end
   endgenerate

   // invalid mode: hold value captured on entry
   logic [1:0] held;
   logic [1:0] pin_val;
   logic [1:0] prim;
   assign prim = {path_out[4], path_out[0]};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         held <= 2'b00;
      end
      else
      begin
         if (pin_ctrl[PROTECT_BIT])
            held <= prim;
      end
   end

   // pin value selection
   always_comb
   begin
      pin_val = prim;
      if (!pin_ctrl[PROTECT_BIT])
      begin
         case (dp_ctrl[INVALID_SEL_LSB +: 2])
            INV_FORCE: pin_val = {2{dp_ctrl[FORCE_BIT]}};
            INV_PASS: pin_val = prim;
            INV_TOGGLE: pin_val = ~held;
            default: pin_val = {chan2_output_pin, chan1_output_pin};
         endcase
      end
   end

   // output pins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         chan1_output_pin <= 1'b0;
         chan2_output_pin <= 1'b0;
      end
      else
      begin
         chan1_output_pin <= pin_val[0];
         chan2_output_pin <= pin_ctrl[PIN_MODE_BIT] ? irq_level : pin_val[1];
      end
   end

   // 10 us step prescaler for the pulse timer
   logic [9:0] pre;
   logic step;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pre <= 10'h000;
         step <= 1'b0;
      end
      else
      begin
         step <= (pre == 10'(PULSE_STEP_CYC - 1));
         pre <= (pre == 10'(PULSE_STEP_CYC - 1)) ? 10'h000 : pre + 10'h001;
      end
   end

   // programmable load: pulse then constant level
   logic load_on;
   logic [1:0] prim_q;
   logic [11:0] ptime [2];
   logic [1:0] pact;
   assign load_on = load_en_cfg[LOAD_EN_LSB +: 2] != 2'b00;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prim_q <= 2'b00;
         ptime <= '{default: 12'h000};
         pact <= 2'b00;
      end
      else
      begin
         prim_q <= prim;
         for (int c = 0; c < 2; c++)
         begin
            if (!load_on)
               pact[c] <= 1'b0;
            else if (prim[c] && !prim_q[c] && pulse_duration_cfg[11:0] != 12'h000)
            begin
               pact[c] <= 1'b1;
               ptime[c] <= pulse_duration_cfg[11:0];
            end
            else if (pact[c] && step)
            begin
               ptime[c] <= ptime[c] - 12'h001;
               if (ptime[c] == 12'h001)
                  pact[c] <= 1'b0;
            end
         end
      end
   end

   // load level outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         load_level_ch1 <= 8'h00;
         load_level_ch2 <= 8'h00;
         load_pulse_ch1 <= 1'b0;
         load_pulse_ch2 <= 1'b0;
      end
      else
      begin
         load_pulse_ch1 <= pact[0];
         load_pulse_ch2 <= pact[1];
         load_level_ch1 <= !load_on ? 8'h00 : pact[0] ? pulse_level_cfg[7:0] : {2'h0, const_level_cfg[5:0]};
         load_level_ch2 <= !load_on ? 8'h00 : pact[1] ? pulse_level_cfg[7:0] : {2'h0, const_level_cfg[5:0]};
      end
   end
endmodule : bid_top

//--- hw/bid_pkg.sv
package bid_pkg;
   // register byte offsets
   localparam logic [7:0] DP_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PIN_CTRL_ADDR = 8'h04;
   localparam logic [7:0] FILT_CFG_ADDR = 8'h10;
   localparam logic [7:0] THR_ADDR = 8'h20;
   localparam logic [7:0] LOAD_EN_ADDR = 8'h30;
   localparam logic [7:0] PULSE_LEVEL_ADDR = 8'h34;
   localparam logic [7:0] PULSE_DUR_ADDR = 8'h38;
   localparam logic [7:0] CONST_LEVEL_ADDR = 8'h3C;
   localparam logic [7:0] STATUS_ADDR = 8'h40;
   // field positions
   localparam int DECIM_EN_BIT = 0;
   localparam int DECIM_RATIO_LSB = 1;
   localparam int FORCE_BIT = 3;
   localparam int INVALID_SEL_LSB = 4;
   localparam int CMP_MODE_LSB = 6;
   localparam int PROTECT_BIT = 0;
   localparam int PIN_MODE_BIT = 2;
   localparam int FILT_EN_BIT = 15;
   localparam int FILT_MODE_BIT = 14;
   localparam int LOAD_EN_LSB = 14;
   // compare mode codes
   localparam logic [1:0] CMP_HYST = 2'h0;
   localparam logic [1:0] CMP_MID = 2'h1;
   localparam logic [1:0] CMP_ABOVE = 2'h2;
   localparam logic [1:0] CMP_BELOW = 2'h3;
   // invalid mode selections
   localparam logic [1:0] INV_FORCE = 2'h0;
   localparam logic [1:0] INV_PASS = 2'h1;
   localparam logic [1:0] INV_TOGGLE = 2'h2;
   // reset values
   localparam logic [31:0] DP_CTRL_RST = 32'h0000_3600;
   localparam logic [31:0] PIN_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] FILT_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] THR_RST = 32'h0000_0000;
   localparam logic [31:0] LOAD_RST = 32'h0000_0000;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int PULSE_STEP_NS = 10000;
   localparam int PULSE_STEP_CYC = (PULSE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // one path's settings
   typedef struct packed {
      logic en;
      logic updown;
      logic [12:0] len;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [1:0] cmode;
   } bid_path_cfg_s;
   // one converter sample
   typedef struct packed {
      logic valid;
      logic chan;
      logic [7:0] data;
   } bid_sample_s;
endpackage : bid_pkg

//--- testbench/bid_top_properties.sv
`timescale 1ns/1ps
module bid_top_properties
   import bid_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins and load
   input wire logic irq_level,
   input wire logic chan1_output_pin,
   input wire logic chan2_output_pin,
   input wire logic [7:0] load_level_ch1,
   input wire logic load_pulse_ch1
);
   logic [31:0] dp;
   logic [2:0] pc;
   logic [1:0] le;
   logic [7:0] pl;
   logic [11:0] dur;
   logic [3:0] quiet;
   int pcnt;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // write taken on the bus
   wire logic wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // shadow of settings, quiet counts cycles since last write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dp <= DP_CTRL_RST;
         pc <= '0;
         le <= '0;
         pl <= '0;
         dur <= '0;
         quiet <= '0;
      end
      else if (wtake)
      begin
         quiet <= '0;
         case (s_axi_awaddr)
            DP_CTRL_ADDR: dp <= s_axi_wdata;
            PIN_CTRL_ADDR: pc <= s_axi_wdata[2:0];
            LOAD_EN_ADDR: le <= s_axi_wdata[15:14];
            PULSE_LEVEL_ADDR: pl <= s_axi_wdata[7:0];
            PULSE_DUR_ADDR: dur <= s_axi_wdata[11:0];
            default: ;
         endcase
      end
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
   end
   // length of the current pulse
   always_ff @(posedge aclk)
      pcnt <= (!aresetn || !load_pulse_ch1) ? 0 : pcnt + 1;
   property p_force;
      !pc[0] && dp[5:4] == INV_FORCE && quiet > 5 |->
         chan1_output_pin == dp[3] && (pc[2] || chan2_output_pin == dp[3]);
   endproperty
   a_force: assert property (p_force) else $error("forced pin value wrong");
   property p_still;
      !pc[0] && dp[5] && quiet > 5 |=> $stable(chan1_output_pin);
   endproperty
   a_still: assert property (p_still) else $error("pin moved in hold or toggle");
   property p_irq;
      (pc[0] && pc[2] && quiet > 5 && $stable(irq_level)) [*3] |-> chan2_output_pin == irq_level;
   endproperty
   a_irq: assert property (p_irq) else $error("pin 2 not following irq level");
   property p_noload;
      le == 2'h0 && quiet > 5 |-> load_level_ch1 == 8'h00 && !load_pulse_ch1;
   endproperty
   a_noload: assert property (p_noload) else $error("load active while disabled");
   property p_plevel;
      $rose(load_pulse_ch1) && quiet > 5 |-> load_level_ch1 == pl;
   endproperty
   a_plevel: assert property (p_plevel) else $error("pulse level wrong");
   property p_pdur;
      $fell(load_pulse_ch1) |-> pcnt + PULSE_STEP_CYC >= dur * PULSE_STEP_CYC
         && pcnt <= (dur + 1) * PULSE_STEP_CYC;
   endproperty
   a_pdur: assert property (p_pdur) else $error("pulse length wrong");
   property p_wans;
      wtake |=> s_axi_bvalid && !s_axi_awready;
   endproperty
   a_wans: assert property (p_wans) else $error("write response late");
   property p_pair;
      s_axi_awready |-> s_axi_wready ##1 !s_axi_awready;
   endproperty
   a_pair: assert property (p_pair) else $error("write ready pair wrong");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   c_pulse: cover property ($rose(load_pulse_ch1));
   c_force: cover property (!pc[0] && dp[5:4] == INV_FORCE && quiet > 5 && chan1_output_pin);
   c_irq: cover property (pc[2] && chan2_output_pin);
endmodule : bid_top_properties

bind bid_top bid_top_properties bid_top_properties_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .irq_level, .chan1_output_pin, .chan2_output_pin, .load_level_ch1,
   .load_pulse_ch1);

//--- testbench/bid_adc_model.sv
`timescale 1ns/1ps
module bid_adc_model
   import bid_pkg::*;
#(
   parameter int GAP = 8
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // analog levels seen on each input
   input wire logic [7:0] level_ch1,
   input wire logic [7:0] level_ch2,
   // converter output
   output bid_sample_s sample
);
   int cnt;
   // one shared converter, channels taken in turn
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt <= 0;
         sample <= '0;
      end
      else
      begin
         cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
         sample.valid <= (cnt == GAP - 1);
         if (cnt == GAP - 1)
         begin
            sample.chan <= ~sample.chan;
            sample.data <= sample.chan ? level_ch1 : level_ch2;
         end
         else
            sample.data <= ~sample.data; // no stale data between samples
      end
   end
endmodule : bid_adc_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench
   import bid_pkg::*;
;
   localparam logic [7:0] HI = 8'h80;
   localparam logic [7:0] LO = 8'h40;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_level;
   logic chan1_output_pin, chan2_output_pin, load_pulse_ch1, load_pulse_ch2;
   logic [7:0] s_axi_awaddr, s_axi_araddr, lvl1, lvl2, load_level_ch1, load_level_ch2, st;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   bid_sample_s sample;
   int errors, compares, n;
   bid_adc_model #(.GAP(8)) bid_adc_model_i (.aclk, .aresetn, .level_ch1(lvl1), .level_ch2(lvl2), .sample);
   bid_top bid_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample,
      .irq_level, .chan1_output_pin, .chan2_output_pin, .load_level_ch1, .load_level_ch2, .load_pulse_ch1,
      .load_pulse_ch2);
   // free running clock
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // bus write, response code left in rr
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   // bus read into rv and rr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // wait for n channel 1 samples and let them reach the pins
   task automatic upd(input int k);
      repeat (k)
         do @(posedge aclk); while (!(sample.valid === 1'b1 && sample.chan === 1'b0));
      repeat (5) @(posedge aclk);
   endtask : upd
   function automatic logic cmpf(input logic [1:0] m, input logic [7:0] s, input logic p);
      case (m)
         CMP_HYST: return (s > HI) ? 1'b1 : (s < LO) ? 1'b0 : p;
         CMP_MID: return (s > LO && s < HI) ? 1'b1 : (s < LO || s > HI) ? 1'b0 : p;
         CMP_ABOVE: return (s > HI) ? 1'b1 : (s < HI) ? 1'b0 : p;
         default: return s <= HI;
      endcase
   endfunction : cmpf
   task automatic t_regs;
      rd(DP_CTRL_ADDR);
      chk("ctrl reset", 32'h0000_3600, rv);
      rd(8'h50);
      chk("unmapped read", 32'h2, {30'h0, rr});
      wr(STATUS_ADDR, 32'hFFFF_FFFF);
      chk("status write", 32'h2, {30'h0, rr});
   endtask : t_regs
   // all four paths on both channels against a value table
   task automatic t_cmp(input logic [31:0] modes);
      logic [7:0] a1 [7] = '{8'h90, 8'h80, 8'h60, 8'h30, 8'h40, 8'hA0, 8'h80};
      logic [7:0] a2 [7] = '{8'h30, 8'h60, 8'h90, 8'h80, 8'h40, 8'h30, 8'h50};
      for (int i = 0; i < 7; i++)
      begin
         lvl1 <= a1[i];
         lvl2 <= a2[i];
         upd(2);
         for (int p = 0; p < 4; p++)
         begin
            st[p] = cmpf(modes[6 + 2 * p +: 2], a1[i], st[p]);
            st[p + 4] = cmpf(modes[6 + 2 * p +: 2], a2[i], st[p + 4]);
         end
         rd(STATUS_ADDR);
         chk("status", {24'h0, st}, rv);
         chk("pins", {30'h0, st[4], st[0]}, {30'h0, chan2_output_pin, chan1_output_pin});
      end
   endtask : t_cmp
   // debounce pattern with clear, reload and count down
   task automatic t_filt(input logic [31:0] cfg, input logic [10:0] e);
      logic [10:0] pat = 11'b00010111011;
      lvl1 <= 8'h30;
      lvl2 <= 8'h30;
      upd(2);
      wr(FILT_CFG_ADDR, cfg);
      upd(2);
      for (int i = 0; i < 11; i++)
      begin
         lvl1 <= pat[i] ? 8'h90 : 8'h30;
         lvl2 <= pat[i] ? 8'h90 : 8'h30;
         upd(1);
         chk("filter", {31'h0, e[i]}, {31'h0, chan1_output_pin});
      end
   endtask : t_filt
   task automatic t_inv;
      wr(PIN_CTRL_ADDR, 32'h0);
      wr(DP_CTRL_ADDR, 32'h0000_3608);
      upd(1);
      chk("force", 32'h3, {30'h0, chan2_output_pin, chan1_output_pin});
      wr(DP_CTRL_ADDR, 32'h0000_3638);
      upd(2);
      chk("hold", 32'h3, {30'h0, chan2_output_pin, chan1_output_pin});
      wr(DP_CTRL_ADDR, 32'h0000_3618);
      upd(1);
      chk("pass", 32'h0, {30'h0, chan2_output_pin, chan1_output_pin});
      wr(DP_CTRL_ADDR, 32'h0000_3628);
      upd(1);
      chk("toggle", 32'h3, {30'h0, chan2_output_pin, chan1_output_pin});
      wr(PIN_CTRL_ADDR, 32'h5);
      irq_level <= 1'b1;
      upd(1);
      chk("irq pin", 32'h2, {30'h0, chan2_output_pin, chan1_output_pin});
   endtask : t_inv
   task automatic t_load;
      wr(FILT_CFG_ADDR, 32'h0000_8000);
      chk("no load", 32'h0, {24'h0, load_level_ch1});
      wr(PULSE_LEVEL_ADDR, 32'h64);
      wr(PULSE_DUR_ADDR, 32'h2);
      wr(CONST_LEVEL_ADDR, 32'h5);
      wr(LOAD_EN_ADDR, 32'h0000_C000);
      lvl1 <= 8'h90;
      do @(posedge aclk); while (load_pulse_ch1 !== 1'b1);
      chk("pulse level", 32'h64, {24'h0, load_level_ch1});
      for (n = 0; load_pulse_ch1 === 1'b1; n++) @(posedge aclk);
      chk("pulse time", 32'h1, {31'h0, n >= 500 && n <= 1500});
      repeat (2) @(posedge aclk);
      chk("const level", 32'h5, {24'h0, load_level_ch1});
      chk("ch2 load", 32'h5, {23'h0, load_pulse_ch2, load_level_ch2});
   endtask : t_load
   // watchdog
   initial
   begin
      #1_000_000;
      errors++;
      close_out;
   end
   // main sequence
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq_level} = '0;
      {s_axi_awaddr, s_axi_araddr, lvl1, lvl2, st, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      errors = 0;
      compares = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      wr(PIN_CTRL_ADDR, 32'h1);
      for (int p = 0; p < 4; p++)
      begin
         wr(FILT_CFG_ADDR + 8'(4 * p), 32'h0000_8000);
         wr(THR_ADDR + 8'(4 * p), 32'h0000_8040);
      end
      t_cmp(DP_CTRL_RST);
      wr(DP_CTRL_ADDR, 32'h0000_2340);
      t_cmp(32'h0000_2340);
      wr(DP_CTRL_ADDR, 32'h0000_3607);
      lvl1 <= 8'h88;
      upd(20);
      rd(STATUS_ADDR);
      chk("decimated", 32'h3, {28'h0, rv[3:0]});
      wr(DP_CTRL_ADDR, DP_CTRL_RST);
      t_filt(32'h0000_8003, 11'b01111100000);
      t_filt(32'h0000_C003, 11'b01111110000);
      t_inv;
      t_load;
      close_out;
   end
endmodule : testbench
